// file: logic/wdt_top.sv
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module wdt_top (
	input wire logic MCLK_I,
	input wire logic SRST_I,
	input wire logic WDT_OSC_I,
	input wire logic ALWAYS_ON_I,
	input wire logic STOP_MODE_I,
	input wire logic AXI_AWVALID_I,
	output logic AXI_AWREADY_O,
	input wire logic [7:0] AXI_AWADDR_I,
	input wire logic AXI_WVALID_I,
	output logic AXI_WREADY_O,
	input wire logic [31:0] AXI_WDATA_I,
	input wire logic [3:0] AXI_WSTRB_I,
	output logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	output logic [1:0] AXI_BRESP_O,
	input wire logic AXI_ARVALID_I,
	output logic AXI_ARREADY_O,
	input wire logic [7:0] AXI_ARADDR_I,
	output logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	output logic [31:0] AXI_RDATA_O,
	output logic [1:0] AXI_RRESP_O,
	output logic SYS_RESET_O,
	output logic STOP_RECOVERY_O,
	output logic WDT_IRQ_O
);
	wdt_pkg::wdt_state_t st_ff;
	wdt_pkg::wdt_state_t nxt_st;
	logic osc_tick;
	logic [23:0] cnt;
	logic expire;
	logic wr_go;
	logic wr_map;
	logic wr_eff;
	logic wr_ctrl;
	logic unl_val;
	logic refresh_wr;
	logic start;
	logic ld;
	logic ar_take;
	logic rd_map;
	logic [31:0] rd_val;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == wdt_pkg::OFS_CTRL) || (a == wdt_pkg::OFS_RLD_U) ||
			(a == wdt_pkg::OFS_RLD_H) || (a == wdt_pkg::OFS_RLD_L) ||
			(a == wdt_pkg::OFS_REFRESH) || (a == wdt_pkg::OFS_COUNT) ||
			(a == wdt_pkg::OFS_IST) || (a == wdt_pkg::OFS_IMASK);
	endfunction : addr_ok

	// ==========================================================
	// watchdog oscillator and counter
	wdt_osc_sync u_sync (
		.clk_i(MCLK_I),
		.rst_i(SRST_I),
		.osc_i(WDT_OSC_I),
		.rise_o(osc_tick)
	);

	wdt_down_counter u_cnt (
		.clk_i(MCLK_I),
		.rst_i(SRST_I),
		.tick_i(osc_tick),
		.run_i(st_ff.running),
		.load_i(ld),
		.value_i(st_ff.reload),
		.count_o(cnt),
		.expire_o(expire)
	);

	// ==========================================================
	// write decode
	assign wr_go = st_ff.aw_have & st_ff.w_have & ~st_ff.bvalid;
	assign wr_map = addr_ok(st_ff.awaddr);
	assign wr_eff = wr_go & wr_map & st_ff.wlane;
	assign wr_ctrl = wr_eff & (st_ff.awaddr == wdt_pkg::OFS_CTRL);
	assign unl_val = (st_ff.wbyte == wdt_pkg::UNLOCK_1) ||
		(st_ff.wbyte == wdt_pkg::UNLOCK_2);
	assign refresh_wr = wr_eff & (st_ff.awaddr == wdt_pkg::OFS_REFRESH);
	assign start = ~st_ff.running & (st_ff.ao | refresh_wr);
	assign ld = start | (refresh_wr & st_ff.running &
		(cnt > wdt_pkg::NO_REFRESH_LVL));

	// ==========================================================
	// read decode
	assign ar_take = AXI_ARVALID_I & ~st_ff.rvalid;
	assign rd_map = addr_ok(AXI_ARADDR_I);

	always_comb begin
		rd_val = 32'h00000000;
		case (AXI_ARADDR_I)
			wdt_pkg::OFS_CTRL: begin
				rd_val[wdt_pkg::CTRL_RUN_BIT] = st_ff.running;
				rd_val[wdt_pkg::CTRL_IRQ_SEL_BIT] = st_ff.irq_sel;
				rd_val[wdt_pkg::CTRL_STOP_BIT] = st_ff.stop_flag;
				rd_val[wdt_pkg::CTRL_TMO_BIT] = st_ff.tmo_flag;
			end
			wdt_pkg::OFS_RLD_U: rd_val[7:0] = st_ff.reload[23:16];
			wdt_pkg::OFS_RLD_H: rd_val[7:0] = st_ff.reload[15:8];
			wdt_pkg::OFS_RLD_L: rd_val[7:0] = st_ff.reload[7:0];
			wdt_pkg::OFS_COUNT: rd_val[23:0] = cnt;
			wdt_pkg::OFS_IST: rd_val[1:0] = st_ff.ist;
			wdt_pkg::OFS_IMASK: rd_val[1:0] = st_ff.imask;
			default: rd_val = 32'h00000000;
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rst_pulse = 1'b0;
		nxt_st.stop_pulse = 1'b0;
		// bus channels
		if (AXI_AWVALID_I && !st_ff.aw_have) begin
			nxt_st.aw_have = 1'b1;
			nxt_st.awaddr = AXI_AWADDR_I;
		end
		if (AXI_WVALID_I && !st_ff.w_have) begin
			nxt_st.w_have = 1'b1;
			nxt_st.wbyte = AXI_WDATA_I[7:0];
			nxt_st.wlane = AXI_WSTRB_I[0];
		end
		if (st_ff.bvalid && AXI_BREADY_I) begin
			nxt_st.bvalid = 1'b0;
		end
		if (wr_go) begin
			nxt_st.aw_have = 1'b0;
			nxt_st.w_have = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = wr_map ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
		end
		// unlock sequence: every mapped write with byte lane 0 enabled steps or resets it
		if (wr_eff) begin
			nxt_st.lock = wdt_pkg::LK_LOCKED;
			case (st_ff.lock)
				wdt_pkg::LK_LOCKED: begin
					if (wr_ctrl && st_ff.wbyte == wdt_pkg::UNLOCK_1) begin
						nxt_st.lock = wdt_pkg::LK_FIRST;
					end
				end
				wdt_pkg::LK_FIRST: begin
					if (wr_ctrl && st_ff.wbyte == wdt_pkg::UNLOCK_2) begin
						nxt_st.lock = wdt_pkg::LK_UPPER;
					end
				end
				wdt_pkg::LK_UPPER: begin
					if (st_ff.awaddr == wdt_pkg::OFS_RLD_U) begin
						nxt_st.reload[23:16] = st_ff.wbyte;
						nxt_st.lock = wdt_pkg::LK_HIGH;
					end
				end
				wdt_pkg::LK_HIGH: begin
					if (st_ff.awaddr == wdt_pkg::OFS_RLD_H) begin
						nxt_st.reload[15:8] = st_ff.wbyte;
						nxt_st.lock = wdt_pkg::LK_LOW;
					end
				end
				wdt_pkg::LK_LOW: begin
					if (st_ff.awaddr == wdt_pkg::OFS_RLD_L) begin
						nxt_st.reload[7:0] = st_ff.wbyte;
					end
					nxt_st.lock = wdt_pkg::LK_LOCKED;
				end
				default: nxt_st.lock = wdt_pkg::LK_LOCKED;
			endcase
		end
		if (wr_ctrl && !unl_val) begin
			nxt_st.irq_sel = st_ff.wbyte[wdt_pkg::CTRL_IRQ_SEL_BIT];
		end
		if (wr_eff && st_ff.awaddr == wdt_pkg::OFS_IMASK) begin
			nxt_st.imask = st_ff.wbyte[1:0];
		end
		if (start) begin
			nxt_st.running = 1'b1;
		end
		// reads, with clear-on-read side effects
		if (st_ff.rvalid && AXI_RREADY_I) begin
			nxt_st.rvalid = 1'b0;
		end
		if (ar_take) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd_val;
			nxt_st.rresp = rd_map ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
			if (AXI_ARADDR_I == wdt_pkg::OFS_CTRL) begin
				nxt_st.tmo_flag = 1'b0;
				nxt_st.stop_flag = 1'b0;
			end
			if (AXI_ARADDR_I == wdt_pkg::OFS_IST) begin
				nxt_st.ist = 2'h0;
			end
		end
		// time-out response, placed after the read clears so a set beats a clear
		if (expire) begin
			if (st_ff.irq_sel) begin
				nxt_st.ist[wdt_pkg::IST_TMO_IRQ_BIT] = 1'b1;
			end else begin
				nxt_st.ist[wdt_pkg::IST_TMO_RST_BIT] = 1'b1;
				nxt_st.tmo_flag = 1'b1;
				if (STOP_MODE_I) begin
					nxt_st.stop_flag = 1'b1;
					nxt_st.stop_pulse = 1'b1;
				end else begin
					nxt_st.rst_pulse = 1'b1;
				end
			end
		end
		if (SRST_I) begin
			nxt_st = wdt_pkg::WDT_STATE_RST;
			nxt_st.ao = ALWAYS_ON_I;
		end
	end

	always_ff @(posedge MCLK_I) begin
		st_ff <= nxt_st;
	end

	// ==========================================================
	// outputs
	assign AXI_AWREADY_O = ~st_ff.aw_have;
	assign AXI_WREADY_O = ~st_ff.w_have;
	assign AXI_BVALID_O = st_ff.bvalid;
	assign AXI_BRESP_O = st_ff.bresp;
	assign AXI_ARREADY_O = ~st_ff.rvalid;
	assign AXI_RVALID_O = st_ff.rvalid;
	assign AXI_RDATA_O = st_ff.rdata;
	assign AXI_RRESP_O = st_ff.rresp;
	assign SYS_RESET_O = st_ff.rst_pulse;
	assign STOP_RECOVERY_O = st_ff.stop_pulse;
	assign WDT_IRQ_O = |(st_ff.ist & st_ff.imask);

	// ==========================================================
	// checks
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (SRST_I);

	sequence s_first_ok;
		st_ff.lock == wdt_pkg::LK_LOCKED && wr_ctrl &&
			st_ff.wbyte == wdt_pkg::UNLOCK_1;
	endsequence
	sequence s_second_ok;
		st_ff.lock == wdt_pkg::LK_FIRST && wr_ctrl &&
			st_ff.wbyte == wdt_pkg::UNLOCK_2;
	endsequence
	sequence s_upper_wr;
		st_ff.lock == wdt_pkg::LK_UPPER && wr_eff &&
			st_ff.awaddr == wdt_pkg::OFS_RLD_U;
	endsequence

	a_unlock_steps: assert property (s_first_ok |=>
		st_ff.lock == wdt_pkg::LK_FIRST)
		else $error("first unlock write not taken");
	a_unlock_second: assert property (s_second_ok |=>
		st_ff.lock == wdt_pkg::LK_UPPER)
		else $error("second unlock write not taken");
	a_upper_store: assert property (s_upper_wr |=>
		st_ff.reload[23:16] == $past(st_ff.wbyte) &&
		st_ff.lock == wdt_pkg::LK_HIGH)
		else $error("upper reload byte not stored");
	a_locked_ignore: assert property ((st_ff.lock == wdt_pkg::LK_LOCKED)
		|=> $stable(st_ff.reload))
		else $error("reload changed while locked");
	a_stray_relock: assert property ((wr_eff &&
		st_ff.lock == wdt_pkg::LK_UPPER &&
		st_ff.awaddr != wdt_pkg::OFS_RLD_U) |=>
		st_ff.lock == wdt_pkg::LK_LOCKED)
		else $error("stray write did not relock");
	a_low_relock: assert property ((wr_eff &&
		st_ff.lock == wdt_pkg::LK_LOW) |=> st_ff.lock == wdt_pkg::LK_LOCKED)
		else $error("sequence did not lock after low byte");
	a_ctrl_keep: assert property ((wr_ctrl && unl_val) |=>
		$stable(st_ff.irq_sel))
		else $error("unlock value changed control bits");
	a_refresh_floor: assert property ((refresh_wr && st_ff.running &&
		cnt <= wdt_pkg::NO_REFRESH_LVL) |-> !ld)
		else $error("refresh reloaded below floor");
	a_start_load: assert property (start |=>
		st_ff.running && cnt == $past(st_ff.reload))
		else $error("counter not loaded at enable");
	a_ao_start: assert property ((st_ff.ao && !st_ff.running) |=>
		st_ff.running)
		else $error("always-on did not start counting");
	a_run_sticky: assert property (st_ff.running |=> st_ff.running)
		else $error("watchdog switched off");
	a_reset_resp: assert property ((expire && !st_ff.irq_sel &&
		!STOP_MODE_I) |=> SYS_RESET_O && st_ff.tmo_flag && !STOP_RECOVERY_O)
		else $error("reset response missing");
	a_stop_resp: assert property ((expire && !st_ff.irq_sel &&
		STOP_MODE_I) |=> STOP_RECOVERY_O && st_ff.stop_flag &&
		st_ff.tmo_flag && !SYS_RESET_O)
		else $error("stop recovery response missing");
	a_irq_resp: assert property ((expire && st_ff.irq_sel) |=>
		!SYS_RESET_O && !STOP_RECOVERY_O &&
		st_ff.ist[wdt_pkg::IST_TMO_IRQ_BIT])
		else $error("interrupt response wrong");
	a_reload_dflt: assert property (@(posedge MCLK_I)
		$past(SRST_I) |-> st_ff.reload == wdt_pkg::RELOAD_RST)
		else $error("reload not at default after reset");
	a_bresp_once: assert property ((wr_go) |=> AXI_BVALID_O ##0
		(AXI_BRESP_O == (($past(wr_map)) ? wdt_pkg::RESP_OKAY :
		wdt_pkg::RESP_SLVERR)))
		else $error("write response wrong");
endmodule : wdt_top
`default_nettype wire

// file: logic/wdt_pkg.sv
`default_nettype none
package wdt_pkg;
	// ==========================================================
	// register offsets (byte addresses, one word each)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RLD_U = 8'h04;
	localparam logic [7:0] OFS_RLD_H = 8'h08;
	localparam logic [7:0] OFS_RLD_L = 8'h0c;
	localparam logic [7:0] OFS_REFRESH = 8'h10;
	localparam logic [7:0] OFS_COUNT = 8'h14;
	localparam logic [7:0] OFS_IST = 8'h18;
	localparam logic [7:0] OFS_IMASK = 8'h1c;
	// ==========================================================
	// field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_IRQ_SEL_BIT = 1;
	localparam int CTRL_STOP_BIT = 6;
	localparam int CTRL_TMO_BIT = 7;
	localparam int IST_TMO_IRQ_BIT = 0;
	localparam int IST_TMO_RST_BIT = 1;
	// ==========================================================
	// values
	localparam logic [23:0] RELOAD_RST = 24'h000400;
	localparam logic [23:0] NO_REFRESH_LVL = 24'h000002;
	localparam logic [23:0] MIN_RELOAD = 24'h000004;
	localparam logic [7:0] UNLOCK_1 = 8'h55;
	localparam logic [7:0] UNLOCK_2 = 8'haa;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		LK_LOCKED = 3'b000,
		LK_FIRST = 3'b001,
		LK_UPPER = 3'b010,
		LK_HIGH = 3'b011,
		LK_LOW = 3'b100
	} lock_t;
	typedef struct packed {
		logic aw_have;
		logic [7:0] awaddr;
		logic w_have;
		logic [7:0] wbyte;
		logic wlane;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		lock_t lock;
		logic [23:0] reload;
		logic running;
		logic irq_sel;
		logic ao;
		logic tmo_flag;
		logic stop_flag;
		logic [1:0] ist;
		logic [1:0] imask;
		logic rst_pulse;
		logic stop_pulse;
	} wdt_state_t;
	localparam wdt_state_t WDT_STATE_RST = '{
		lock: LK_LOCKED, reload: RELOAD_RST, default: '0};
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_state_t;
	typedef struct packed {
		logic [23:0] count;
		logic expire;
	} cnt_state_t;
	localparam cnt_state_t CNT_STATE_RST = '{count: RELOAD_RST, expire: 1'b0};
endpackage : wdt_pkg
`default_nettype wire

// file: logic/wdt_osc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module wdt_osc_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic osc_i,
	output logic rise_o
);
	wdt_pkg::sync_state_t st_ff;
	wdt_pkg::sync_state_t nxt_st;

	// ==========================================================
	// two-stage synchroniser, then rising-edge detect
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = osc_i;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		if (rst_i) begin
			nxt_st = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st;
	end

	assign rise_o = st_ff.s2 & ~st_ff.s3;
endmodule : wdt_osc_sync
`default_nettype wire

// file: logic/wdt_down_counter.sv
`timescale 1ns/10ps
`default_nettype none
module wdt_down_counter (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic load_i,
	input wire logic [23:0] value_i,
	output logic [23:0] count_o,
	output logic expire_o
);
	wdt_pkg::cnt_state_t st_ff;
	wdt_pkg::cnt_state_t nxt_st;

	// ==========================================================
	// count down on oscillator ticks, reload on terminal count
	always_comb begin
		nxt_st = st_ff;
		nxt_st.expire = 1'b0;
		if (load_i) begin
			nxt_st.count = value_i;
		end else if (run_i && tick_i) begin
			if (st_ff.count <= 24'h000001) begin
				nxt_st.count = value_i;
				nxt_st.expire = 1'b1;
			end else begin
				nxt_st.count = st_ff.count - 24'h000001;
			end
		end
		if (rst_i) begin
			nxt_st = wdt_pkg::CNT_STATE_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st;
	end

	assign count_o = st_ff.count;
	assign expire_o = st_ff.expire;

	a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
		(run_i && tick_i && !load_i && st_ff.count > 24'h000001)
		|=> st_ff.count == $past(st_ff.count) - 24'h000001)
		else $error("counter did not step down by one");
	a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(!tick_i && !load_i) |=> $stable(st_ff.count) && !st_ff.expire)
		else $error("counter moved without a tick");
endmodule : wdt_down_counter
`default_nettype wire

// file: testbench/wdt_osc_model.sv
`timescale 1ns/10ps
`default_nettype none
module wdt_osc_model (
	output logic osc_o
);
	// ==========================================================
	// oscillator: stands still between bursts of ticks
	initial osc_o = 1'b0;
	task pulse(input int n);
		// step off the clock edge so the synchroniser never races
		#1;
		for (int i = 0; i < n; i++) begin
			#100 osc_o = 1'b1;
			#100 osc_o = 1'b0;
		end
	endtask : pulse
endmodule : wdt_osc_model
`default_nettype wire

// file: testbench/wdt_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module wdt_top_bench;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic ao = 1'b0;
	logic stop = 1'b0;
	logic osc, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h00000000, rdat, v;
	logic awr, wrdy, bv, arr, rv, sys_rst, stp_rec, irq;
	logic [1:0] br, rr, resp, wr_resp;
	int err_count = 0, compares = 0, rst_seen = 0, stop_seen = 0;
	always #2.5 mclk = ~mclk;
	wdt_osc_model osc_m (.osc_o(osc));
	wdt_top dut (.MCLK_I(mclk), .SRST_I(srst), .WDT_OSC_I(osc),
		.ALWAYS_ON_I(ao), .STOP_MODE_I(stop), .AXI_AWVALID_I(awv),
		.AXI_AWREADY_O(awr), .AXI_AWADDR_I(awa), .AXI_WVALID_I(wv),
		.AXI_WREADY_O(wrdy), .AXI_WDATA_I(wd), .AXI_WSTRB_I(4'hf),
		.AXI_BVALID_O(bv), .AXI_BREADY_I(bry), .AXI_BRESP_O(br),
		.AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_ARADDR_I(ara),
		.AXI_RVALID_O(rv), .AXI_RREADY_I(rry), .AXI_RDATA_O(rdat),
		.AXI_RRESP_O(rr), .SYS_RESET_O(sys_rst),
		.STOP_RECOVERY_O(stp_rec), .WDT_IRQ_O(irq));
	// pulses are counted mid-cycle, away from the edge that launches them
	always @(negedge mclk) begin
		if (sys_rst === 1'b1) rst_seen++;
		if (stp_rec === 1'b1) stop_seen++;
	end
	// ==========================================================
	// checking and closing
	task report_and_stop;
		$display("mismatches %0d, compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	initial begin
		#100000;
		chk("run time", 32'h0, 32'h1);
		report_and_stop();
	end
	// ==========================================================
	// bus cycles: ready values sampled before the edge they act on
	task wr(input logic [7:0] a, input logic [31:0] d);
		bit sa, sw, done;
		done = 0;
		@(posedge mclk);
		awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bry <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(negedge mclk);
			sa = awv && awr;
			sw = wv && wrdy;
			done = (bv === 1'b1);
			wr_resp = br;
			@(posedge mclk);
			if (sa) awv <= 1'b0;
			if (sw) wv <= 1'b0;
			if (done) bry <= 1'b0;
		end
		if (!done) begin
			chk("write answer", 32'h0, 32'h1);
			report_and_stop();
		end
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit sa, done;
		done = 0;
		@(posedge mclk);
		arv <= 1'b1; ara <= a; rry <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(negedge mclk);
			sa = arv && arr;
			done = (rv === 1'b1);
			d = rdat;
			r = rr;
			@(posedge mclk);
			if (sa) arv <= 1'b0;
			if (done) rry <= 1'b0;
		end
		if (!done) begin
			chk("read answer", 32'h0, 32'h1);
			report_and_stop();
		end
	endtask : rd
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a, v, resp);
		chk(nm, v, e);
	endtask : rchk
	task ticks(input int n);
		osc_m.pulse(n);
		repeat (8) @(posedge mclk);
	endtask : ticks
	// ==========================================================
	// scenarios
	task t_reset;
		rchk("upper", wdt_pkg::OFS_RLD_U, 32'h00000000);
		rchk("high", wdt_pkg::OFS_RLD_H, 32'h00000004);
		rchk("low", wdt_pkg::OFS_RLD_L, 32'h00000000);
		rchk("ctrl off", wdt_pkg::OFS_CTRL, 32'h00000000);
		rd(8'h20, v, resp);
		chk("unmapped resp", {30'h0, resp}, 32'h00000002);
		chk("unmapped data", v, 32'h00000000);
		wr(8'h20, 32'h00000000);
		chk("unmapped wresp", {30'h0, wr_resp}, 32'h00000002);
	endtask : t_reset
	task t_lock;
		wr(wdt_pkg::OFS_CTRL, 32'h00000002);
		chk("ctrl wresp", {30'h0, wr_resp}, 32'h00000000);
		wr(wdt_pkg::OFS_CTRL, 32'h00000055);
		rchk("ctrl kept", wdt_pkg::OFS_CTRL, 32'h00000002);
		wr(wdt_pkg::OFS_IMASK, 32'h00000000);
		wr(wdt_pkg::OFS_CTRL, 32'h000000aa);
		wr(wdt_pkg::OFS_RLD_U, 32'h00000011);
		rchk("broken seq", wdt_pkg::OFS_RLD_U, 32'h00000000);
		wr(wdt_pkg::OFS_CTRL, 32'h00000000);
		wr(wdt_pkg::OFS_CTRL, 32'h00000055);
		wr(wdt_pkg::OFS_CTRL, 32'h000000aa);
		wr(wdt_pkg::OFS_RLD_U, 32'h00000000);
		wr(wdt_pkg::OFS_RLD_H, 32'h00000000);
		wr(wdt_pkg::OFS_RLD_L, 32'h00000008);
		rchk("high new", wdt_pkg::OFS_RLD_H, 32'h00000000);
		rchk("low new", wdt_pkg::OFS_RLD_L, 32'h00000008);
		wr(wdt_pkg::OFS_RLD_U, 32'h00000022);
		rchk("relocked", wdt_pkg::OFS_RLD_U, 32'h00000000);
	endtask : t_lock
	task t_count;
		wr(wdt_pkg::OFS_REFRESH, 32'h00000001);
		rchk("running", wdt_pkg::OFS_CTRL, 32'h00000001);
		rchk("first load", wdt_pkg::OFS_COUNT, 32'h00000008);
		ticks(5);
		rchk("counting", wdt_pkg::OFS_COUNT, 32'h00000003);
		wr(wdt_pkg::OFS_REFRESH, 32'h00000001);
		rchk("refresh", wdt_pkg::OFS_COUNT, 32'h00000008);
		ticks(6);
		wr(wdt_pkg::OFS_REFRESH, 32'h00000001);
		rchk("late refresh", wdt_pkg::OFS_COUNT, 32'h00000002);
		ticks(2);
		chk("reset pulses", rst_seen, 32'h00000001);
		rchk("tmo flag", wdt_pkg::OFS_CTRL, 32'h00000081);
		rchk("flag cleared", wdt_pkg::OFS_CTRL, 32'h00000001);
		rchk("reloaded", wdt_pkg::OFS_COUNT, 32'h00000008);
	endtask : t_count
	task t_stop;
		@(posedge mclk);
		stop <= 1'b1;
		ticks(8);
		chk("recoveries", stop_seen, 32'h00000001);
		chk("no reset", rst_seen, 32'h00000001);
		rchk("both flags", wdt_pkg::OFS_CTRL, 32'h000000c1);
		rchk("ist reset", wdt_pkg::OFS_IST, 32'h00000002);
		chk("masked irq", {31'h0, irq}, 32'h00000000);
		stop <= 1'b0;
	endtask : t_stop
	task t_irq;
		wr(wdt_pkg::OFS_CTRL, 32'h00000002);
		wr(wdt_pkg::OFS_IMASK, 32'h00000001);
		ticks(8);
		chk("irq up", {31'h0, irq}, 32'h00000001);
		chk("no reset", rst_seen, 32'h00000001);
		rchk("ist irq", wdt_pkg::OFS_IST, 32'h00000001);
		chk("irq cleared", {31'h0, irq}, 32'h00000000);
	endtask : t_irq
	task t_ao;
		@(posedge mclk);
		ao <= 1'b1;
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		repeat (3) @(posedge mclk);
		rchk("always on", wdt_pkg::OFS_CTRL, 32'h00000001);
		rchk("ao load", wdt_pkg::OFS_COUNT, 32'h00000400);
	endtask : t_ao
	initial begin
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		t_reset();
		t_lock();
		t_count();
		t_stop();
		t_irq();
		t_ao();
		report_and_stop();
	end
endmodule : wdt_top_bench
`default_nettype wire
